// ==== rtl/arab_pkg.sv ====
package arab_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADR_W     = 12;
  localparam int unsigned ADR_LSB   = 2;
  localparam int unsigned IDX_W     = ADR_W - ADR_LSB;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned SEL_W     = DATA_W / BYTE_W;

  // register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TABLE_PORT_SELECT  = 10'h06e;
  localparam logic [IDX_W-1:0] IDX_INDIRECT_OFFSET    = 10'h06f;
  localparam logic [IDX_W-1:0] IDX_INDIRECT_WINDOW    = 10'h0a0;

  ////////////////////////////////////////////////////////////////////////////
  // table/port select register layout
  localparam int unsigned      CTRL_TABLE_HI = 7;
  localparam int unsigned      CTRL_TABLE_LO = 5;
  localparam int unsigned      CTRL_PORT_HI  = 3;
  localparam int unsigned      CTRL_PORT_LO  = 0;
  localparam logic [2:0]       TABLE_RULE    = 3'h2;
  localparam logic [3:0]       PORT_FIRST    = 4'h1;
  localparam logic [3:0]       PORT_LAST     = 4'h4;

  // indirect byte offsets covered by this bank
  localparam logic [7:0]       OFFS_RULE_BYTE_8            = 8'h08;
  localparam logic [7:0]       OFFS_RULE_BYTE_9            = 8'h09;
  localparam logic [7:0]       OFFS_RULE_ACTION_PRIORITY   = 8'h0a;
  localparam logic [7:0]       OFFS_RULE_ACTION_BYTE_11    = 8'h0b;

  // storage geometry: four ports by four bytes
  localparam int unsigned      PORT_IDX_W   = 2;
  localparam int unsigned      BYTE_IDX_W   = 2;
  localparam int unsigned      ENTRY_W      = PORT_IDX_W + BYTE_IDX_W;
  localparam int unsigned      RULE_ENTRIES = 16;
  localparam logic [BYTE_IDX_W-1:0] ACTION_BYTE_IDX = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // action byte fields
  localparam int unsigned      MODE_HI   = 7;
  localparam int unsigned      MODE_LO   = 6;
  localparam int unsigned      PRIO_HI   = 5;
  localparam int unsigned      PRIO_LO   = 3;
  localparam int unsigned      RPE_BIT   = 2;
  localparam int unsigned      RVAL_HI   = 1;
  localparam int unsigned      RVAL_LO   = 0;

  localparam logic [1:0]       MODE_KEEP    = 2'h0;
  localparam logic [1:0]       MODE_HIGHER  = 2'h1;
  localparam logic [1:0]       MODE_LOWER   = 2'h2;
  localparam logic [1:0]       MODE_REPLACE = 2'h3;

  // reset values
  localparam logic [7:0]       BYTE_RESET = 8'h00;
  localparam logic [2:0]       PRIO_RESET = 3'h0;
  localparam logic [1:0]       RVAL_RESET = 2'h0;

endpackage

// ==== rtl/arab_prio_resolve.sv ====
`timescale 1ns/1ns
module arab_prio_resolve (
  input  wire logic [1:0] mode_i,
  input  wire logic [2:0] rule_prio_i,
  input  wire logic [2:0] class_prio_i,
  input  wire logic       tagged_i,
  output logic      [2:0] prio_o
);
  import arab_pkg::*;

  always_comb begin
    prio_o = class_prio_i;
    // untagged frames always keep the classification result
    if (tagged_i) begin
      case (mode_i)
        MODE_KEEP: begin
          prio_o = class_prio_i;
        end
        MODE_HIGHER: begin
          if (rule_prio_i > class_prio_i) begin
            prio_o = rule_prio_i;
          end
        end
        MODE_LOWER: begin
          if (rule_prio_i < class_prio_i) begin
            prio_o = rule_prio_i;
          end
        end
        MODE_REPLACE: begin
          prio_o = rule_prio_i;
        end
        default: begin
          prio_o = class_prio_i;
        end
      endcase
    end
  end

endmodule

// ==== rtl/arab_core.sv ====
// How it works
// - select bits 3..0 choose the port; only ports 1 to 4 are valid
// - offset register value 0x08..0x0b picks rule byte 8 to 11
// - window register at indirect_byte_window shows and writes the selected rule byte
// - mode 00: tagged frames keep classification priority
// - mode 01: rule priority used only when above classification
// - mode 10: rule priority used only when below classification
// - mode 11: rule priority always replaces tagged frame priority
// - rule priority sits in bits 5..3, applied per mode bits 7..6
// - remark enable 0 leaves VLAN priority bits unchanged
// - remark enable 1 replaces VLAN priority with remark value bits 1..0
// - remark value maps directly to levels 0 to 3
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
module arab_core (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [arab_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [arab_pkg::SEL_W-1:0]    wb_sel_i,
  input  wire logic [arab_pkg::DATA_W-1:0]   wb_dat_i,
  output logic                               wb_ack_o,
  output logic      [arab_pkg::DATA_W-1:0]   wb_dat_o,
  input  wire logic                          match_i,
  input  wire logic [3:0]                    match_port_i,
  input  wire logic                          match_tagged_i,
  input  wire logic [2:0]                    class_prio_i,
  output logic                               act_valid_o,
  output logic      [2:0]                    act_prio_o,
  output logic                               act_remark_o,
  output logic      [1:0]                    act_remark_level_o
);
  import arab_pkg::*;

  typedef enum {ST_IDLE, ST_FETCH} arab_xfer_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  arab_xfer_state_e          state;
  arab_xfer_state_e          next_state;
  logic [BYTE_W-1:0]         table_port_sel;
  logic [BYTE_W-1:0]         next_table_port_sel;
  logic [BYTE_W-1:0]         byte_offset;
  logic [BYTE_W-1:0]         next_byte_offset;
  logic [BYTE_W-1:0]         window;
  logic [BYTE_W-1:0]         next_window;
  logic [BYTE_W-1:0]         rule_mem      [RULE_ENTRIES];
  logic [BYTE_W-1:0]         next_rule_mem [RULE_ENTRIES];
  logic                      next_ack;
  logic [DATA_W-1:0]         next_dat;
  logic                      next_act_valid;
  logic [2:0]                next_act_prio;
  logic                      next_act_remark;
  logic [1:0]                next_act_remark_level;

  logic                      wb_take;
  logic [IDX_W-1:0]          wb_idx;
  logic                      hit_sel;
  logic                      hit_offs;
  logic                      hit_win;
  logic                      lane_wr;
  logic                      sel_table_ok;
  logic                      sel_port_ok;
  logic                      sel_offs_ok;
  logic                      sel_valid;
  logic [ENTRY_W-1:0]        sel_entry;
  logic [BYTE_W-1:0]         fetch_data;
  logic                      rule_wr;
  logic                      match_port_ok;
  logic [ENTRY_W-1:0]        match_entry;
  logic [BYTE_W-1:0]         action_byte;
  logic [2:0]                resolved_prio;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; a new request is refused while a fetch is in flight
  assign wb_take  = wb_cyc_i && wb_stb_i && !wb_ack_o && (state == ST_IDLE);
  assign wb_idx   = wb_adr_i[ADR_W-1:ADR_LSB];
  assign hit_sel  = (wb_idx == IDX_TABLE_PORT_SELECT);
  assign hit_offs = (wb_idx == IDX_INDIRECT_OFFSET);
  assign hit_win  = (wb_idx == IDX_INDIRECT_WINDOW);
  assign lane_wr  = wb_take && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // indirect selection: table, port and byte offset
  assign sel_table_ok = (table_port_sel[CTRL_TABLE_HI:CTRL_TABLE_LO] == TABLE_RULE);
  assign sel_port_ok  = (table_port_sel[CTRL_PORT_HI:CTRL_PORT_LO] >= PORT_FIRST) &&
                        (table_port_sel[CTRL_PORT_HI:CTRL_PORT_LO] <= PORT_LAST);
  assign sel_offs_ok  = (byte_offset >= OFFS_RULE_BYTE_8) &&
                        (byte_offset <= OFFS_RULE_ACTION_BYTE_11);
  assign sel_valid    = sel_table_ok && sel_port_ok && sel_offs_ok;
  assign sel_entry    = {PORT_IDX_W'(table_port_sel[CTRL_PORT_HI:CTRL_PORT_LO] - PORT_FIRST),
                         BYTE_IDX_W'(byte_offset - OFFS_RULE_BYTE_8)};
  // out-of-range selections read as zero instead of aliasing onto a real byte
  assign fetch_data   = sel_valid ? rule_mem[sel_entry] : BYTE_RESET;
  assign rule_wr      = lane_wr && hit_win && sel_valid;

  ////////////////////////////////////////////////////////////////////////////
  // register file and indirect transfer
  always_comb begin
    next_state          = ST_IDLE;
    next_table_port_sel = table_port_sel;
    next_byte_offset    = byte_offset;
    next_window         = window;
    next_ack            = wb_take;
    next_dat            = '0;
    case (state)
      ST_IDLE: begin
        if (lane_wr && hit_sel) begin
          next_table_port_sel = wb_dat_i[BYTE_W-1:0];
          next_state          = ST_FETCH;
        end
        if (lane_wr && hit_offs) begin
          next_byte_offset = wb_dat_i[BYTE_W-1:0];
          next_state       = ST_FETCH;
        end
        if (lane_wr && hit_win) begin
          next_window = wb_dat_i[BYTE_W-1:0];
        end
      end
      ST_FETCH: begin
        // selection registers are settled now, so the window reloads cleanly
        next_window = fetch_data;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (wb_take && !wb_we_i) begin
      if (hit_sel) begin
        next_dat = {{(DATA_W-BYTE_W){1'b0}}, table_port_sel};
      end else if (hit_offs) begin
        next_dat = {{(DATA_W-BYTE_W){1'b0}}, byte_offset};
      end else if (hit_win) begin
        next_dat = {{(DATA_W-BYTE_W){1'b0}}, window};
      end else begin
        next_dat = '0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state          <= ST_IDLE;
      table_port_sel <= BYTE_RESET;
      byte_offset    <= BYTE_RESET;
      window         <= BYTE_RESET;
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= '0;
    end else begin
      state          <= next_state;
      table_port_sel <= next_table_port_sel;
      byte_offset    <= next_byte_offset;
      window         <= next_window;
      wb_ack_o       <= next_ack;
      wb_dat_o       <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rule storage, one write port through the window
  for (genvar g = 0; g < RULE_ENTRIES; g++) begin : g_entry
    always_comb begin
      next_rule_mem[g] = rule_mem[g];
      if (rule_wr && (sel_entry == ENTRY_W'(g))) begin
        next_rule_mem[g] = wb_dat_i[BYTE_W-1:0];
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        rule_mem[g] <= BYTE_RESET;
      end else begin
        rule_mem[g] <= next_rule_mem[g];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // action datapath: one lookup per match pulse, registered result
  assign match_port_ok = (match_port_i >= PORT_FIRST) && (match_port_i <= PORT_LAST);
  assign match_entry   = {PORT_IDX_W'(match_port_i - PORT_FIRST), ACTION_BYTE_IDX};
  assign action_byte   = rule_mem[match_entry];

  arab_prio_resolve u_resolve (
    .mode_i       (action_byte[MODE_HI:MODE_LO]),
    .rule_prio_i  (action_byte[PRIO_HI:PRIO_LO]),
    .class_prio_i (class_prio_i),
    .tagged_i     (match_tagged_i),
    .prio_o       (resolved_prio)
  );

  always_comb begin
    next_act_valid        = 1'b0;
    next_act_prio         = act_prio_o;
    next_act_remark       = 1'b0;
    next_act_remark_level = act_remark_level_o;
    if (match_i && match_port_ok) begin
      next_act_valid  = 1'b1;
      next_act_prio   = resolved_prio;
      // remark low tells the datapath to leave the VLAN priority bits alone
      next_act_remark = action_byte[RPE_BIT];
      // the two-bit value is the level itself, no table lookup
      next_act_remark_level = action_byte[RVAL_HI:RVAL_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_valid_o        <= 1'b0;
      act_prio_o         <= PRIO_RESET;
      act_remark_o       <= 1'b0;
      act_remark_level_o <= RVAL_RESET;
    end else begin
      act_valid_o        <= next_act_valid;
      act_prio_o         <= next_act_prio;
      act_remark_o       <= next_act_remark;
      act_remark_level_o <= next_act_remark_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic                      m_ok;
  logic [1:0]                m_mode;
  logic [2:0]                m_rule;
  assign m_ok   = match_i && match_port_ok && match_tagged_i;
  assign m_mode = action_byte[MODE_HI:MODE_LO];
  assign m_rule = action_byte[PRIO_HI:PRIO_LO];

  ack_latency_a: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o && state == ST_IDLE) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not given one cycle after request");

  fetch_stall_a: assert property (
    (wb_ack_o && $past(lane_wr && hit_offs)) |-> state == ST_FETCH ##1
      (state == ST_IDLE && !wb_ack_o))
    else $error("offset write did not run one fetch cycle");

  window_load_a: assert property (
    (state == ST_FETCH) |=> window == $past(fetch_data))
    else $error("window not loaded from selected rule byte");

  window_read_a: assert property (
    (wb_take && !wb_we_i && hit_win) |=> wb_dat_o[BYTE_W-1:0] == $past(window))
    else $error("window read returned wrong byte");

  rule_store_a: assert property (
    rule_wr |=> rule_mem[$past(sel_entry)] == $past(wb_dat_i[BYTE_W-1:0]))
    else $error("window write did not reach rule storage");

  bad_select_a: assert property (
    (state == ST_FETCH && !sel_port_ok) |=> window == BYTE_RESET)
    else $error("invalid port selection did not read zero");

  mode_keep_a: assert property (
    (m_ok && m_mode == MODE_KEEP) |=> act_valid_o && act_prio_o == $past(class_prio_i))
    else $error("mode keep changed priority");

  mode_higher_a: assert property (
    (m_ok && m_mode == MODE_HIGHER) |=> act_prio_o ==
      (($past(m_rule) > $past(class_prio_i)) ? $past(m_rule) : $past(class_prio_i)))
    else $error("mode higher chose wrong priority");

  mode_lower_a: assert property (
    (m_ok && m_mode == MODE_LOWER) |=> act_prio_o ==
      (($past(m_rule) < $past(class_prio_i)) ? $past(m_rule) : $past(class_prio_i)))
    else $error("mode lower chose wrong priority");

  mode_replace_a: assert property (
    (m_ok && m_mode == MODE_REPLACE) |=> act_prio_o == $past(m_rule))
    else $error("mode replace did not use rule priority");

  remark_out_a: assert property (
    (match_i && match_port_ok) |=> act_remark_o == $past(action_byte[RPE_BIT]) &&
      (!act_remark_o || act_remark_level_o == $past(action_byte[RVAL_HI:RVAL_LO])))
    else $error("remark outputs do not follow action byte");

  bad_table_a: assert property (
    (state == ST_FETCH && !sel_table_ok) |=> window == BYTE_RESET)
    else $error("wrong table code did not read zero");

  bad_offset_a: assert property (
    (state == ST_FETCH && !sel_offs_ok) |=> window == BYTE_RESET)
    else $error("offset outside the bank did not read zero");

  sel_write_a: assert property (
    (lane_wr && hit_sel) |=> table_port_sel == $past(wb_dat_i[BYTE_W-1:0]))
    else $error("select register write lost");

  offset_write_a: assert property (
    (lane_wr && hit_offs) |=> byte_offset == $past(wb_dat_i[BYTE_W-1:0]))
    else $error("offset register write lost");

  refused_store_a: assert property (
    (lane_wr && hit_win && !sel_valid) |=>
      rule_mem[$past(sel_entry)] == $past(rule_mem[sel_entry]))
    else $error("refused window write changed rule storage");

  unmapped_read_a: assert property (
    (wb_take && !wb_we_i && !hit_sel && !hit_offs && !hit_win) |=> wb_dat_o == '0)
    else $error("unmapped read returned data");

  upper_zero_a: assert property (
    wb_ack_o |-> wb_dat_o[DATA_W-1:BYTE_W] == '0)
    else $error("upper read data lanes not zero");

  fetch_block_a: assert property (
    (state == ST_FETCH) |=> !wb_ack_o)
    else $error("request answered during a fetch");

  untagged_keep_a: assert property (
    (match_i && match_port_ok && !match_tagged_i) |=> act_prio_o == $past(class_prio_i))
    else $error("untagged frame priority changed");

  remark_off_a: assert property (
    (match_i && match_port_ok && !action_byte[RPE_BIT]) |=> act_valid_o && !act_remark_o)
    else $error("remark asked for with enable clear");

  level_map_a: assert property (
    (match_i && match_port_ok) |=> act_remark_level_o == $past(action_byte[RVAL_HI:RVAL_LO]))
    else $error("remark level not taken as is");

  no_action_a: assert property (
    !(match_i && match_port_ok) |=> !act_valid_o && !act_remark_o)
    else $error("action pulse for an invalid or absent match");

  action_hold_a: assert property (
    !(match_i && match_port_ok) |=> $stable(act_prio_o) && $stable(act_remark_level_o))
    else $error("action outputs moved without a match");

  offset_write_c: cover property (lane_wr && hit_offs ##2 state == ST_IDLE);
  rule_write_c:   cover property (rule_wr);
  higher_win_c:   cover property (m_ok && m_mode == MODE_HIGHER && m_rule > class_prio_i);
  remark_c:       cover property (match_i && match_port_ok && action_byte[RPE_BIT]);
  bad_select_c:   cover property (state == ST_FETCH && !sel_valid);

endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import arab_pkg::*;

  logic                 clk_i;
  logic                 rst_i;
  logic                 wb_cyc_i;
  logic                 wb_stb_i;
  logic                 wb_we_i;
  logic [ADR_W-1:0]     wb_adr_i;
  logic [SEL_W-1:0]     wb_sel_i;
  logic [DATA_W-1:0]    wb_dat_i;
  logic                 wb_ack_o;
  logic [DATA_W-1:0]    wb_dat_o;
  logic                 match_i;
  logic [3:0]           match_port_i;
  logic                 match_tagged_i;
  logic [2:0]           class_prio_i;
  logic                 act_valid_o;
  logic [2:0]           act_prio_o;
  logic                 act_remark_o;
  logic [1:0]           act_remark_level_o;
  int                   error_cnt;
  int                   tests_run;
  // bit 32 set means the read data is compared; writes leave it clear
  logic [32:0]          rd_q[$];
  logic [5:0]           act_q[$];
  logic [7:0]           mem [1:4][0:3];

  arab_core u_arab_core (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .wb_cyc_i           (wb_cyc_i),
    .wb_stb_i           (wb_stb_i),
    .wb_we_i            (wb_we_i),
    .wb_adr_i           (wb_adr_i),
    .wb_sel_i           (wb_sel_i),
    .wb_dat_i           (wb_dat_i),
    .wb_ack_o           (wb_ack_o),
    .wb_dat_o           (wb_dat_o),
    .match_i            (match_i),
    .match_port_i       (match_port_i),
    .match_tagged_i     (match_tagged_i),
    .class_prio_i       (class_prio_i),
    .act_valid_o        (act_valid_o),
    .act_prio_o         (act_prio_o),
    .act_remark_o       (act_remark_o),
    .act_remark_level_o (act_remark_level_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task final_report();
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the master never assumes a latency; it waits for ack under a bound
  task automatic wb(input logic we, input logic [IDX_W-1:0] idx, input logic [7:0] d,
                    input logic [3:0] sel, input logic chk, input logic [7:0] exp);
    int          n;
    logic [31:0] w;
    w = $urandom();
    w[7:0] = d;
    rd_q.push_back({chk, 24'h0, exp});
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o === 1'b1) begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end else begin
      error_cnt++;
      $display("Error at %0t: bus answer timed out", $time);
      final_report();
    end
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'h1, 1'b0, 8'h00);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'($urandom()), 4'h1, 1'b1, exp);
  endtask

  task automatic pick(input logic [2:0] tbl, input logic [3:0] port, input logic [7:0] off);
    wr(IDX_TABLE_PORT_SELECT, {tbl, 1'b0, port});
    wr(IDX_INDIRECT_OFFSET, off);
  endtask

  // expected {priority, remark flag, remark level} for one matching frame
  function automatic logic [5:0] act_exp(input logic [7:0] ab, input logic tg,
                                         input logic [2:0] cp);
    logic [2:0] p;
    p = cp;
    if (tg) begin
      case (ab[7:6])
        MODE_HIGHER:  if (ab[5:3] > cp) p = ab[5:3];
        MODE_LOWER:   if (ab[5:3] < cp) p = ab[5:3];
        MODE_REPLACE: p = ab[5:3];
        default:      p = cp;
      endcase
    end
    return {p, ab[2], ab[1:0]};
  endfunction

  // back-to-back matches, one per cycle, invalid ports among them
  task automatic burst(input int n);
    logic [3:0] pt;
    logic       tg;
    logic [2:0] cp;
    for (int i = 0; i < n; i++) begin
      pt = 4'($urandom_range(0, 5));
      tg = 1'($urandom());
      cp = 3'($urandom());
      @(posedge clk_i);
      match_i        <= 1'b1;
      match_port_i   <= pt;
      match_tagged_i <= tg;
      class_prio_i   <= cp;
      if (pt >= 4'h1 && pt <= 4'h4) act_q.push_back(act_exp(mem[pt][2], tg, cp));
    end
    @(posedge clk_i);
    match_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watcher: every answer is matched against the oldest note
  always @(posedge clk_i) begin
    logic [32:0] e;
    logic [5:0]  a;
    if (wb_ack_o === 1'b1) begin
      e = rd_q.pop_front();
      if (e[32]) check(wb_dat_o, e[31:0]);
    end
    if (act_valid_o === 1'b1) begin
      if (act_q.size() == 0) begin
        error_cnt++;
        $display("Error at %0t: action pulse without a valid match", $time);
      end else begin
        a = act_q.pop_front();
        check({29'h0, act_prio_o}, {29'h0, a[5:3]});
        check({31'h0, act_remark_o}, {31'h0, a[2]});
        if (a[2]) check({30'h0, act_remark_level_o}, {30'h0, a[1:0]});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    {wb_cyc_i, wb_stb_i, wb_we_i, match_i, match_tagged_i} = 5'h00;
    wb_adr_i = '0;
    wb_sel_i = '0;
    wb_dat_i = '0;
    match_port_i = 4'h0;
    class_prio_i = 3'h0;
    error_cnt = 0;
    tests_run = 0;
    rst_i = 1'b1;
    void'($urandom(32'hb13a5dc6));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_TABLE_PORT_SELECT, 8'h00);
    rd(IDX_INDIRECT_OFFSET, 8'h00);
    rd(IDX_INDIRECT_WINDOW, 8'h00);
    // fill every byte of every port; the action byte gets mode = port - 1
    for (int p = 1; p <= 4; p++) begin
      for (int b = 0; b < 4; b++) begin
        d = 8'($urandom());
        if (b == 2) d[7:6] = 2'(p - 1);
        mem[p][b] = d;
        pick(TABLE_RULE, 4'(p), OFFS_RULE_BYTE_8 + 8'(b));
        wr(IDX_INDIRECT_WINDOW, d);
      end
    end
    // read back through a fresh selection; the select and offset registers are read back before the window
    for (int p = 1; p <= 4; p++) begin
      for (int b = 0; b < 4; b++) begin
        pick(TABLE_RULE, 4'(p), OFFS_RULE_BYTE_8 + 8'(b));
        rd(IDX_TABLE_PORT_SELECT, {TABLE_RULE, 1'b0, 4'(p)});
        rd(IDX_INDIRECT_OFFSET, OFFS_RULE_BYTE_8 + 8'(b));
        rd(IDX_INDIRECT_WINDOW, mem[p][b]);
      end
    end
    // refused selections must neither show nor change storage
    pick(3'h3, 4'h1, OFFS_RULE_ACTION_PRIORITY);
    rd(IDX_INDIRECT_WINDOW, 8'h00);
    wr(IDX_INDIRECT_WINDOW, 8'hff);
    pick(TABLE_RULE, 4'h5, OFFS_RULE_ACTION_PRIORITY);
    rd(IDX_INDIRECT_WINDOW, 8'h00);
    wr(IDX_INDIRECT_WINDOW, 8'hff);
    pick(TABLE_RULE, 4'h1, 8'h0c);
    rd(IDX_INDIRECT_WINDOW, 8'h00);
    wr(IDX_INDIRECT_WINDOW, 8'hff);
    wr(10'h010, 8'h33);
    rd(10'h010, 8'h00);
    pick(TABLE_RULE, 4'h1, OFFS_RULE_ACTION_PRIORITY);
    wb(1'b1, IDX_INDIRECT_WINDOW, 8'h5a, 4'he, 1'b0, 8'h00);
    rd(IDX_INDIRECT_WINDOW, mem[1][2]);
    burst(60);
    // rotate the modes so each port sees another one
    for (int p = 1; p <= 4; p++) begin
      d = 8'($urandom());
      d[7:6] = 2'(p);
      mem[p][2] = d;
      pick(TABLE_RULE, 4'(p), OFFS_RULE_ACTION_PRIORITY);
      wr(IDX_INDIRECT_WINDOW, d);
    end
    burst(60);
    repeat (4) @(posedge clk_i);
    check(32'(act_q.size()), 32'h0);
    check(32'(rd_q.size()), 32'h0);
    final_report();
  end
endmodule
